// *** common/output_clock_driver_defines.vh ***
// Register map, field positions and codes for the output clock driver control.
`ifndef OUTPUT_CLOCK_DRIVER_DEFINES_VH
`define OUTPUT_CLOCK_DRIVER_DEFINES_VH

// ============================================================
// Register indices (byte address is four times the index)
`define APB_ADDR_W          12
`define IDX_W               10
`define IDX_GLOBAL_GATE     10'h102
`define IDX_DRIVER_CONFIG   10'h108
`define IDX_FORMAT_CONTROL  10'h109
`define IDX_SWING_AMPLITUDE 10'h10A
`define IDX_STATUS          10'h150
`define IDX_DIVIDER_VALUE   10'h151

// ============================================================
// Driver configuration fields
`define CFG_PDN_BIT         0
`define CFG_OE_BIT          1
`define CFG_FORCE_HALF_BIT  2

// ============================================================
// Format control fields
`define FMT_SEL_HI          2
`define FMT_SEL_LO          0
`define FMT_SYNC_BIT        3
`define FMT_DIS_HI          5
`define FMT_DIS_LO          4
`define FMT_IMP_HI          7
`define FMT_IMP_LO          6

// ============================================================
// Swing register fields
`define SWG_CM_HI           3
`define SWG_CM_LO           0
`define SWG_AMP_HI          6
`define SWG_AMP_LO          4

// ============================================================
// Format codes and disabled levels
`define FMT_DIFF_NORMAL     3'h1
`define FMT_DIFF_HIGH       3'h2
`define FMT_RESERVED_3      3'h3
`define FMT_SE_BOTH         3'h4
`define FMT_SE_PLUS         3'h5
`define FMT_SE_MINUS        3'h6
`define DIS_LEVEL_LOW       2'h0
`define DIS_LEVEL_HIGH      2'h1

// ============================================================
// Reset values and divider constants
`define RST_DRIVER_CONFIG   8'h00
`define RST_FORMAT_CONTROL  8'h00
`define RST_SWING_AMPLITUDE 8'h00
`define RST_GLOBAL_GATE     8'h01
`define RST_DIVIDER_VALUE   8'h00
`define HALF_PERIOD_FORCED  9'h001
`define HALF_PERIOD_ONE     9'h001

`endif

// *** hw/output_clock_driver_control.v ***
// Control logic for one clock output driver: registers, final divider and glitchless gating.
//
// Functional notes
// - Config bit 0 powers the regulator down.
// - Powered down: both pins weakly pulled low.
// - Config bit 1 enables the clock output.
// - Config bit 2 forces divide by two.
// - Format bits 2:0 select the driver type.
// - Sync bit gates changes to output clock.
// - Disable-state bits 5:4 pick idle level.
// - Bits 7:6 impedance, single-ended formats only.
// - Common-mode field used for formats 1, 2.
// - Amplitude field used for formats 1, 2, 3.
// - Global gate clear disables every driver.
//
// Chosen here: the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "output_clock_driver_defines.vh"

module output_clock_driver_control
(
    input  wire        clk,              // System clock, 100 MHz.
    input  wire        reset,            // Synchronous reset, active high.
    input  wire        psel,             // APB select.
    input  wire        penable,          // APB access phase.
    input  wire        pwrite,           // APB direction, high for write.
    input  wire [11:0] paddr,            // APB byte address.
    input  wire [31:0] pwdata,           // APB write data.
    output wire        pready,           // APB ready, always high.
    output reg  [31:0] prdata,           // APB read data.
    output reg         pslverr,          // APB error on unmapped address.
    output reg         regulator_off,    // Regulator power-down control.
    output reg         weak_pull_low,    // Weak pull-down on both pins.
    output reg         pin_plus,         // Plus pin level.
    output reg         pin_plus_oe,      // Plus pin actively driven.
    output reg         pin_minus,        // Minus pin level.
    output reg         pin_minus_oe,     // Minus pin actively driven.
    output reg  [1:0]  impedance_sel,    // Single-ended impedance in use.
    output reg  [3:0]  common_mode_sel,  // Common-mode code in use.
    output reg  [2:0]  amplitude_sel     // Amplitude code in use.
);

    // ============================================================
    // Register storage

    reg  [7:0]  driver_config;
    reg  [7:0]  format_control;
    reg  [7:0]  swing_amplitude;
    reg  [7:0]  global_gate;
    reg  [7:0]  divider_value;

    // Gating state and the divided clock itself.
    reg  [8:0]  half_count;
    reg         out_clock;
    reg         gated_enable;
    reg         gated_power_down;

    wire [`IDX_W-1:0] reg_index;
    wire              setup_phase;
    wire              write_strobe;
    wire              index_mapped;
    wire [2:0]        format_sel;
    wire              sync_enable;
    wire [1:0]        disabled_level;
    wire [8:0]        half_period;
    wire              half_done;
    wire              period_boundary;
    wire              next_out_clock;
    wire              requested_enable;
    wire              requested_power_down;
    wire [7:0]        status_word;

    reg  [7:0]        next_read;
    reg               next_enable;
    reg               next_power_down;
    reg               disabled_value;

    // ============================================================
    // APB slave decode

    // Zero wait states: read data is latched in the setup cycle, so the
    // access cycle can always complete and no stall logic is needed.
    assign pready       = 1'b1;
    assign reg_index    = paddr[`APB_ADDR_W-1:2];
    assign setup_phase  = psel & ~penable;
    assign write_strobe = psel & penable & pwrite & ~pslverr;

    assign index_mapped = (reg_index == `IDX_GLOBAL_GATE)
                        | (reg_index == `IDX_DRIVER_CONFIG)
                        | (reg_index == `IDX_FORMAT_CONTROL)
                        | (reg_index == `IDX_SWING_AMPLITUDE)
                        | (reg_index == `IDX_STATUS)
                        | (reg_index == `IDX_DIVIDER_VALUE);

    // Status shows the live gating state and the clock level.
    assign status_word = {5'h00, out_clock, gated_power_down, gated_enable};

    // Read multiplexer; unmapped and unused bits read as zero.
    always @*
    begin
        case (reg_index)
            `IDX_GLOBAL_GATE:     next_read = {7'h00, global_gate[0]};
            `IDX_DRIVER_CONFIG:   next_read = {5'h00, driver_config[2:0]};
            `IDX_FORMAT_CONTROL:  next_read = format_control;
            `IDX_SWING_AMPLITUDE: next_read = {1'b0, swing_amplitude[6:0]};
            `IDX_STATUS:          next_read = status_word;
            `IDX_DIVIDER_VALUE:   next_read = divider_value;
            default:              next_read = 8'h00;
        endcase
    end

    // Read data and error are captured in the setup cycle and held.
    always @(posedge clk)
    begin
        if (reset)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (setup_phase)
        begin
            prdata  <= {24'h000000, next_read};
            pslverr <= ~index_mapped;
        end
    end

    // ============================================================
    // Register writes

    // Writes take effect at the access edge; status is read-only and
    // writes to it are silently dropped.
    always @(posedge clk)
    begin
        if (reset)
        begin
            driver_config   <= `RST_DRIVER_CONFIG;
            format_control  <= `RST_FORMAT_CONTROL;
            swing_amplitude <= `RST_SWING_AMPLITUDE;
            global_gate     <= `RST_GLOBAL_GATE;
            divider_value   <= `RST_DIVIDER_VALUE;
        end
        else if (write_strobe)
        begin
            case (reg_index)
                `IDX_GLOBAL_GATE:     global_gate     <= {7'h00, pwdata[0]};
                `IDX_DRIVER_CONFIG:   driver_config   <= {5'h00, pwdata[2:0]};
                `IDX_FORMAT_CONTROL:  format_control  <= pwdata[7:0];
                `IDX_SWING_AMPLITUDE: swing_amplitude <= {1'b0, pwdata[6:0]};
                `IDX_DIVIDER_VALUE:   divider_value   <= pwdata[7:0];
                default:              divider_value   <= divider_value;
            endcase
        end
    end

    // ============================================================
    // Field extraction

    assign format_sel     = format_control[`FMT_SEL_HI:`FMT_SEL_LO];
    assign sync_enable    = format_control[`FMT_SYNC_BIT];
    assign disabled_level = format_control[`FMT_DIS_HI:`FMT_DIS_LO];

    // output enable through the global gate
    assign requested_enable = driver_config[`CFG_OE_BIT] & global_gate[0];

    assign requested_power_down = driver_config[`CFG_PDN_BIT];

    // ============================================================
    // Final divider

    // forced divide by two overrides the programmed ratio
    // The ratio is even, 2*(value+1); a half period of one cycle is divide by two.
    assign half_period = driver_config[`CFG_FORCE_HALF_BIT] ? `HALF_PERIOD_FORCED
                       : ({1'b0, divider_value} + `HALF_PERIOD_ONE);

    assign half_done = (half_count >= half_period - `HALF_PERIOD_ONE);

    // a period ends when the low half completes
    assign period_boundary = half_done & ~out_clock;

    // Level the clock takes at this edge; pins follow it with no lag.
    assign next_out_clock = half_done ? ~out_clock : out_clock;

    // The divider keeps running while disabled so that boundaries keep coming.
    always @(posedge clk)
    begin
        if (reset)
        begin
            half_count <= 9'h000;
            out_clock  <= 1'b0;
        end
        else if (half_done)
        begin
            half_count <= 9'h000;
            out_clock  <= ~out_clock;
        end
        else
        begin
            half_count <= half_count + 9'h001;
        end
    end

    // ============================================================
    // Glitchless gating

    // synced changes wait for the output clock, others act at once
    always @*
    begin
        next_enable     = gated_enable;
        next_power_down = gated_power_down;
        if (!sync_enable || period_boundary)
        begin
            next_enable     = requested_enable;
            next_power_down = requested_power_down;
        end
    end

    // gate state moves at once, or with sync set only as a low half of the output clock ends
    always @(posedge clk)
    begin
        if (reset)
        begin
            gated_enable     <= 1'b0;
            gated_power_down <= 1'b0;
        end
        else
        begin
            gated_enable     <= next_enable;
            gated_power_down <= next_power_down;
        end
    end

    // ============================================================
    // Pin drive

    // disabled level, reserved codes fall back to low
    always @*
    begin
        case (disabled_level)
            `DIS_LEVEL_LOW:  disabled_value = 1'b0;
            `DIS_LEVEL_HIGH: disabled_value = 1'b1;
            default:         disabled_value = 1'b0;
        endcase
    end

    // Pins are registered so nothing combinational reaches the pads.
    always @(posedge clk)
    begin
        if (reset)
        begin
            regulator_off <= 1'b0;
            weak_pull_low <= 1'b0;
            pin_plus      <= 1'b0;
            pin_plus_oe   <= 1'b0;
            pin_minus     <= 1'b0;
            pin_minus_oe  <= 1'b0;
        end
        else if (next_power_down)
        begin
            // regulator off, pins released to the weak pull
            regulator_off <= 1'b1;
            weak_pull_low <= 1'b1;
            pin_plus      <= 1'b0;
            pin_plus_oe   <= 1'b0;
            pin_minus     <= 1'b0;
            pin_minus_oe  <= 1'b0;
        end
        else if (!next_enable)
        begin
            // disabled driver holds the chosen level
            regulator_off <= 1'b0;
            weak_pull_low <= 1'b0;
            pin_plus      <= disabled_value;
            pin_plus_oe   <= 1'b1;
            pin_minus     <= disabled_value;
            pin_minus_oe  <= 1'b1;
        end
        else
        begin
            regulator_off <= 1'b0;
            weak_pull_low <= 1'b0;
            // driver type from the format code
            case (format_sel)
                `FMT_DIFF_NORMAL, `FMT_DIFF_HIGH:
                begin
                    pin_plus     <= ~next_out_clock;
                    pin_plus_oe  <= 1'b1;
                    pin_minus    <= next_out_clock;
                    pin_minus_oe <= 1'b1;
                end
                `FMT_SE_BOTH:
                begin
                    pin_plus     <= ~next_out_clock;
                    pin_plus_oe  <= 1'b1;
                    pin_minus    <= ~next_out_clock;
                    pin_minus_oe <= 1'b1;
                end
                `FMT_SE_PLUS:
                begin
                    pin_plus     <= ~next_out_clock;
                    pin_plus_oe  <= 1'b1;
                    pin_minus    <= 1'b0;
                    pin_minus_oe <= 1'b0;
                end
                `FMT_SE_MINUS:
                begin
                    pin_plus     <= 1'b0;
                    pin_plus_oe  <= 1'b0;
                    pin_minus    <= ~next_out_clock;
                    pin_minus_oe <= 1'b1;
                end
                default:
                begin
                    // Reserved codes leave both pins undriven.
                    pin_plus     <= 1'b0;
                    pin_plus_oe  <= 1'b0;
                    pin_minus    <= 1'b0;
                    pin_minus_oe <= 1'b0;
                end
            endcase
        end
    end

    // ============================================================
    // Analog setting qualification

    // Settings that do not apply to the chosen format are forced to zero
    // so the analog side never sees a stale code.
    always @(posedge clk)
    begin
        if (reset)
        begin
            impedance_sel   <= 2'h0;
            common_mode_sel <= 4'h0;
            amplitude_sel   <= 3'h0;
        end
        else
        begin
            if ((format_sel == `FMT_SE_BOTH) || (format_sel == `FMT_SE_PLUS)
                || (format_sel == `FMT_SE_MINUS))
                impedance_sel <= format_control[`FMT_IMP_HI:`FMT_IMP_LO];
            else
                impedance_sel <= 2'h0;
            // common mode only for differential formats
            if ((format_sel == `FMT_DIFF_NORMAL) || (format_sel == `FMT_DIFF_HIGH))
                common_mode_sel <= swing_amplitude[`SWG_CM_HI:`SWG_CM_LO];
            else
                common_mode_sel <= 4'h0;
            // amplitude for formats one to three
            if ((format_sel == `FMT_DIFF_NORMAL) || (format_sel == `FMT_DIFF_HIGH)
                || (format_sel == `FMT_RESERVED_3))
                amplitude_sel <= swing_amplitude[`SWG_AMP_HI:`SWG_AMP_LO];
            else
                amplitude_sel <= 3'h0;
        end
    end

endmodule // output_clock_driver_control

`default_nettype wire

// *** testbench/clock_load_model.sv ***
// Behavioural model of the clock loads on the two output pins.
`timescale 1ns/1ns
`default_nettype none
module clock_load_model
(
    input  wire logic clk,           // Sampling clock.
    input  wire logic reset,         // Sync reset.
    input  wire logic pin_plus,      // Plus level.
    input  wire logic pin_plus_oe,   // Plus driven.
    input  wire logic pin_minus,     // Minus level.
    input  wire logic pin_minus_oe,  // Minus driven.
    input  wire logic weak_pull_low, // Pull-down on.
    output var  logic pad_plus,      // Plus pad level.
    output var  logic pad_minus      // Minus pad level.
);
    // ============================================================
    // Pad resolution
    // A floating pad without pull flips each cycle, so a pin left undriven by
    // mistake never passes for a steady level.
    // weak pull low
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pad_plus  <= 1'b0;
            pad_minus <= 1'b0;
        end
        else
        begin
            pad_plus  <= pin_plus_oe ? pin_plus : (weak_pull_low ? 1'b0 : ~pad_plus);
            pad_minus <= pin_minus_oe ? pin_minus : (weak_pull_low ? 1'b0 : ~pad_minus);
        end
    end
endmodule // clock_load_model
`default_nettype wire

// *** testbench/driver_ctrl_properties.sv ***
// Port-level assertions for the output clock driver control block.
`timescale 1ns/1ns
`default_nettype none
module driver_ctrl_properties
(
    input wire logic        clk,             // Clock.
    input wire logic        reset,           // Sync reset.
    input wire logic        psel,            // APB select.
    input wire logic        penable,         // APB access.
    input wire logic        pwrite,          // APB write.
    input wire logic [11:0] paddr,           // APB address.
    input wire logic [31:0] pwdata,          // APB data.
    input wire logic        pslverr,         // APB error.
    input wire logic        regulator_off,   // Power-down.
    input wire logic        weak_pull_low,   // Pull-down.
    input wire logic        pin_plus,        // Plus level.
    input wire logic        pin_plus_oe,     // Plus driven.
    input wire logic        pin_minus,       // Minus level.
    input wire logic        pin_minus_oe,    // Minus driven.
    input wire logic [1:0]  impedance_sel,   // Impedance.
    input wire logic [3:0]  common_mode_sel, // Common mode.
    input wire logic [2:0]  amplitude_sel    // Amplitude.
);
    // ============================================================
    // Shadow registers
    logic       gate;
    logic [2:0] cfg;
    logic [7:0] fmt;
    logic [6:0] swg;
    logic [7:0] div;
    logic [9:0] quiet;
    wire        en = cfg[1] & gate & ~cfg[0];
    wire  [2:0] f = fmt[2:0];
    wire  [1:0] oe_exp = (f == 3'h5) ? 2'b10 : (f == 3'h6) ? 2'b01 :
                         (f == 3'h1 || f == 3'h2 || f == 3'h4) ? 2'b11 : 2'b00;
    // A synced change may wait a whole output period, so allow that plus margin.
    wire        settled = quiet > (cfg[2] ? 10'h008 : {1'b0, div, 1'b0} + 10'h008);

    // Completed writes update the shadows and restart the quiet count.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            gate  <= 1'b1;
            cfg   <= 3'h0;
            fmt   <= 8'h00;
            swg   <= 7'h00;
            div   <= 8'h00;
            quiet <= 10'h000;
        end
        else
        begin
            quiet <= (quiet == 10'h3FF) ? quiet : quiet + 10'h001;
            if (psel && penable && pwrite && !pslverr)
            begin
                quiet <= 10'h000;
                case (paddr)
                    12'h408: gate <= pwdata[0];
                    12'h420: cfg  <= pwdata[2:0];
                    12'h424: fmt  <= pwdata[7:0];
                    12'h428: swg  <= pwdata[6:0];
                    12'h544: div  <= pwdata[7:0];
                    default: ;
                endcase
            end
        end
    end

    // ============================================================
    // Assertions
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (reset);
    a_power_down: assert property (
        settled |-> regulator_off == cfg[0] && weak_pull_low == cfg[0] && !(cfg[0] && (pin_plus_oe || pin_minus_oe)))
        else $error("power-down state wrong");
    a_disabled_level: assert property (
        settled && !cfg[0] && !en |-> pin_plus_oe && pin_minus_oe && pin_plus == (fmt[5:4] == 2'b01)
            && pin_minus == pin_plus)
        else $error("disabled level wrong");
    a_gate_off: assert property (
        settled && !gate && !cfg[0] |-> $stable(pin_plus) && $stable(pin_minus))
        else $error("gated output still moves");
    a_format_oe: assert property (
        settled && en |-> {pin_plus_oe, pin_minus_oe} == oe_exp)
        else $error("pin enables wrong for format");
    a_pin_phase: assert property (
        settled && en && oe_exp == 2'b11 |-> (pin_plus == pin_minus) == (f == 3'h4))
        else $error("pin phase wrong for format");
    a_force_half: assert property (
        settled && en && cfg[2] && f == 3'h1 |-> pin_plus != $past(pin_plus))
        else $error("forced divide by two not toggling");
    a_cm_qualify: assert property (
        $stable({fmt, swg})[*2] |-> common_mode_sel == ((f == 3'h1 || f == 3'h2) ? swg[3:0] : 4'h0))
        else $error("common mode code wrong");
    a_amp_qualify: assert property (
        $stable({fmt, swg})[*2] |-> amplitude_sel == ((f != 3'h0 && f < 3'h4) ? swg[6:4] : 3'h0))
        else $error("amplitude code wrong");
    a_imp_qualify: assert property (
        $stable(fmt)[*2] |-> impedance_sel == ((f >= 3'h4 && f != 3'h7) ? fmt[7:6] : 2'h0))
        else $error("impedance code wrong");
    c_enabled: cover property (settled && en && f == 3'h1);
    c_power_down: cover property (settled && cfg[0]);
    c_gate_off: cover property (settled && !gate && cfg[1]);
endmodule // driver_ctrl_properties

bind output_clock_driver_control driver_ctrl_properties u_driver_ctrl_properties
(
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pslverr(pslverr), .regulator_off(regulator_off), .weak_pull_low(weak_pull_low),
    .pin_plus(pin_plus), .pin_plus_oe(pin_plus_oe), .pin_minus(pin_minus), .pin_minus_oe(pin_minus_oe),
    .impedance_sel(impedance_sel), .common_mode_sel(common_mode_sel), .amplitude_sel(amplitude_sel)
);
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking testbench for the output clock driver control block.
`timescale 1ns/1ns
`default_nettype none
`include "output_clock_driver_defines.vh"
module testbench;
    // ============================================================
    // Signals and bookkeeping
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd, r;
    logic [31:0] seed = 32'h48F8;
    logic        er, pv;
    wire         pready, pslverr, regulator_off, weak_pull_low, pad_plus, pad_minus;
    wire         pin_plus, pin_plus_oe, pin_minus, pin_minus_oe;
    wire  [31:0] prdata;
    wire  [1:0]  impedance_sel;
    wire  [3:0]  common_mode_sel;
    wire  [2:0]  amplitude_sel;
    int          err_count = 0, checks = 0, n;
    localparam logic [11:0] gate_addr = {`IDX_GLOBAL_GATE, 2'b00};
    localparam logic [11:0] cfg_addr = {`IDX_DRIVER_CONFIG, 2'b00};
    localparam logic [11:0] fmt_addr = {`IDX_FORMAT_CONTROL, 2'b00};
    localparam logic [11:0] swg_addr = {`IDX_SWING_AMPLITUDE, 2'b00};
    localparam logic [11:0] div_addr = {`IDX_DIVIDER_VALUE, 2'b00};
    localparam logic [11:0] bad_addr = 12'hFFC;

    // Free-running 100 MHz clock.
    always #5 clk = ~clk;

    output_clock_driver_control u_output_clock_driver_control
    (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .regulator_off(regulator_off),
        .weak_pull_low(weak_pull_low), .pin_plus(pin_plus), .pin_plus_oe(pin_plus_oe), .pin_minus(pin_minus),
        .pin_minus_oe(pin_minus_oe), .impedance_sel(impedance_sel), .common_mode_sel(common_mode_sel),
        .amplitude_sel(amplitude_sel)
    );
    clock_load_model u_clock_load_model
    (
        .clk(clk), .reset(reset), .pin_plus(pin_plus), .pin_plus_oe(pin_plus_oe), .pin_minus(pin_minus),
        .pin_minus_oe(pin_minus_oe), .weak_pull_low(weak_pull_low), .pad_plus(pad_plus), .pad_minus(pad_minus)
    );

    // ============================================================
    // Helpers
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected qualified codes: impedance, common mode, amplitude.
    function logic [31:0] exp_q(input logic [7:0] f, input logic [6:0] s);
        exp_q = {23'h0, (f[2:0] inside {3'h4, 3'h5, 3'h6}) ? f[7:6] : 2'h0,
                 (f[2:0] inside {3'h1, 3'h2}) ? s[3:0] : 4'h0, (f[2:0] inside {3'h1, 3'h2, 3'h3}) ? s[6:4] : 3'h0};
    endfunction

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // One APB transfer; the request holds until pready is seen at an edge.
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdchk(input logic [11:0] a, input logic [31:0] exp, input logic e);
        apb(a, 1'b0, 32'h0);
        chk(rd, exp);
        chk({31'h0, er}, {31'h0, e});
    endtask

    // Length in cycles of the first complete pulse on the plus pad.
    task pulse(output int len);
        logic p;
        int   k;
        k = 0;
        len = 0;
        p = pad_plus;
        while (pad_plus === p && k < 600)
        begin
            @(posedge clk);
            k++;
        end
        p = pad_plus;
        while (pad_plus === p && len < 600)
        begin
            @(posedge clk);
            len++;
        end
    endtask

    task end_sim;
        if (err_count == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ============================================================
    // Watchdog: the tests need a few hundred cycles, so 50,000 means a hang.
    initial
    begin
        #500000;
        err_count++;
        end_sim;
    end

    // Main sequence.
    initial
    begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        rdchk(cfg_addr, 32'h0, 1'b0);
        rdchk(gate_addr, 32'h1, 1'b0);
        apb(bad_addr, 1'b1, 32'hFF);
        rdchk(bad_addr, 32'h0, 1'b1);
        rdchk(swg_addr, 32'h0, 1'b0);
        // Every format code, other fields random; output stays disabled.
        for (int c = 0; c < 8; c++)
        begin
            r = rnd();
            apb(fmt_addr, 1'b1, {24'h0, r[7:3], c[2:0]});
            apb(swg_addr, 1'b1, {25'h0, r[14:8]});
            repeat (3) @(posedge clk);
            chk({23'h0, impedance_sel, common_mode_sel, amplitude_sel}, exp_q({r[7:3], c[2:0]}, r[14:8]));
            rdchk(fmt_addr, {24'h0, r[7:3], c[2:0]}, 1'b0);
        end
        // Power-down wins over an enabled output.
        apb(fmt_addr, 1'b1, 32'h01);
        apb(cfg_addr, 1'b1, 32'h3);
        repeat (12) @(posedge clk);
        chk({26'h0, regulator_off, weak_pull_low, pin_plus_oe, pin_minus_oe, pad_plus, pad_minus}, 32'h30);
        apb(cfg_addr, 1'b1, 32'h0);
        for (int l = 0; l < 2; l++)
        begin
            apb(fmt_addr, 1'b1, {26'h0, l[1:0], 4'h1});
            repeat (12) @(posedge clk);
            chk({28'h0, pin_plus, pin_minus, pin_plus_oe, pin_minus_oe}, {28'h0, l[0], l[0], 2'b11});
        end
        // Forced divide by two, enabled without synchronisation.
        apb(fmt_addr, 1'b1, 32'h01);
        apb(cfg_addr, 1'b1, 32'h6);
        repeat (3) @(posedge clk);
        repeat (8)
        begin
            pv = pin_plus;
            @(posedge clk);
            chk({31'h0, pin_plus}, {31'h0, ~pv});
        end
        for (int f = 2; f < 7; f++)
        begin
            apb(fmt_addr, 1'b1, f);
            repeat (12) @(posedge clk);
            chk({30'h0, pin_plus_oe, pin_minus_oe}, {30'h0, f != 3 && f != 6, f != 3 && f != 5});
        end
        apb(gate_addr, 1'b1, 32'h0);
        repeat (12) @(posedge clk);
        chk({30'h0, pin_plus, pin_plus_oe}, 32'h1);
        apb(gate_addr, 1'b1, 32'h1);
        // Synchronised enable: the first pulse must be a full half period.
        for (int i = 0; i < 3; i++)
        begin
            r = rnd();
            apb(cfg_addr, 1'b1, 32'h0);
            repeat (20) @(posedge clk);
            apb(fmt_addr, 1'b1, 32'h09);
            apb(div_addr, 1'b1, {29'h0, r[2:0]});
            apb(cfg_addr, 1'b1, 32'h2);
            pulse(n);
            chk(n, {29'h0, r[2:0]} + 32'h1);
        end
        end_sim;
    end
endmodule // testbench
`default_nettype wire
